// *** rtl/sample_fifo.v ***
// small synchronous fifo with valid/ready on both sides
module sample_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage array
	reg [AW-1:0] wr_reg; // write pointer
	reg [AW-1:0] rd_reg; // read pointer
	reg [AW:0] cnt_reg; // words held
	wire push; // accepted write
	wire pop; // accepted read

	assign in_ready = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage write, no reset needed on data
	always @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	// pointers and fill count
	always @(posedge clk) begin
		if (rst) begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_reg <= wr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_reg <= rd_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			// simultaneous push and pop leaves count alone
			if (push && !pop) begin
				cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule // sample_fifo

// *** rtl/serial_sar_adc_readout.v ***
// control and serial read-out of a 12-bit successive approximation converter
// Notes on behaviour
// - deselected: conversion stops, block shuts down
// - data output floats whenever deselected
// - each fresh select starts new conversion
// - sample first, then resolve msb down to lsb
// - one latched when trial below input, shown
// - msb-only or msb then lsb-first formats
// - msb-only transfer spans 15 serial clocks
// - dual: lsb at 15, msb at 26
// - after last bit, output zeros
// - 12-bit result; cycle time 30.1/45.15 us
`include "adc_readout_defines.vh"

module serial_sar_adc_readout #(
	// least cycle time in clocks at each supply, long counts kept shortenable
	parameter CYC_HI_CLKS = (`CYC_HI_NS + `CLK_NS - 1) / `CLK_NS,
	parameter CYC_LO_CLKS = (`CYC_LO_NS + `CLK_NS - 1) / `CLK_NS
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// serial pins from the host
	input wire select_shutdown_n,
	input wire sclk,
	// serial data pin, three signals
	input wire dout_in,
	output reg dout_out,
	output reg dout_oe_n,
	// static configuration
	input wire dual_format,
	input wire low_supply,
	// analog front end
	input wire cmp_above,
	output reg sample_hold,
	output reg [`RES_W-1:0] dac_code,
	output reg shutdown,
	// result stream
	output reg result_valid,
	input wire result_ready,
	output reg [`RES_W-1:0] result_data,
	output reg result_short,
	output reg result_overrun
);
	// synchronisers for pins from outside the clock domain
	reg [1:0] sel_sync_reg;
	reg [1:0] sclk_sync_reg;
	reg [1:0] cmp_sync_reg;
	reg [1:0] fmt_sync_reg; // format pin, static but still a pin
	reg [1:0] sup_sync_reg; // supply figure pin
	reg sclk_prev_reg; // for serial clock edge finding
	reg sel_prev_reg; // for select edge finding
	// conversion state
	reg [`STEP_W-1:0] step_reg; // falling serial edges counted
	reg [`RES_W-1:0] sar_reg; // approximation register
	reg [`RES_W-1:0] trial_reg; // trial bit position, one-hot
	reg dual_reg; // format held for this conversion
	reg [`CYC_CNT_W-1:0] cyc_reg; // clocks since select fell
	// pending word waiting for fifo room
	reg pend_reg;
	reg [`RES_W-1:0] pend_data_reg;
	reg pend_short_reg;
	wire fifo_ready;
	wire fifo_out_valid;
	wire [`FIFO_W-1:0] fifo_out_data;
	wire selected;
	wire sclk_fall;
	wire sel_fall;
	wire cyc_short;
	wire [`CYC_CNT_W-1:0] cyc_min;

	// decode: result bit index shown at a given step of the lsb-first tail
	function [3:0] rev_index;
		input [`STEP_W-1:0] s;
		reg [`STEP_W-1:0] d;
		begin
			d = s - `STEP_REV_FIRST;
			rev_index = d[3:0];
		end
	endfunction

	// decode: result bit index resolved at a given msb-first step
	function [3:0] fwd_index;
		input [`STEP_W-1:0] s;
		reg [`STEP_W-1:0] d;
		begin
			d = `STEP_LSB - s;
			fwd_index = d[3:0];
		end
	endfunction

	assign selected = ~sel_sync_reg[1];
	assign sclk_fall = sclk_prev_reg & ~sclk_sync_reg[1];
	assign sel_fall = sel_prev_reg & ~sel_sync_reg[1];
	// least cycle time depends on supply figure
	assign cyc_min = sup_sync_reg[1] ? CYC_LO_CLKS[`CYC_CNT_W-1:0] : CYC_HI_CLKS[`CYC_CNT_W-1:0];
	assign cyc_short = cyc_reg < cyc_min;

	// two-flop synchronisers; second stage only is looked at
	always @(posedge clk) begin
		if (rst) begin
			sel_sync_reg <= 2'h3;
			sclk_sync_reg <= 2'h0;
			cmp_sync_reg <= 2'h0;
			fmt_sync_reg <= 2'h0;
			sup_sync_reg <= 2'h0;
			sclk_prev_reg <= 1'b0;
			sel_prev_reg <= 1'b1;
		end else begin
			sel_sync_reg <= {sel_sync_reg[0], select_shutdown_n};
			sclk_sync_reg <= {sclk_sync_reg[0], sclk};
			cmp_sync_reg <= {cmp_sync_reg[0], cmp_above};
			// configuration pins may change at any time, so they are synced too
			fmt_sync_reg <= {fmt_sync_reg[0], dual_format};
			sup_sync_reg <= {sup_sync_reg[0], low_supply};
			sclk_prev_reg <= sclk_sync_reg[1];
			sel_prev_reg <= sel_sync_reg[1];
		end
	end

	// conversion sequencer, paced by falling serial clock edges
	always @(posedge clk) begin
		if (rst) begin
			step_reg <= `STEP_ZERO;
			sar_reg <= `RES_ZERO;
			trial_reg <= `RES_ZERO;
			dual_reg <= 1'b0;
			cyc_reg <= `CYC_CNT_ZERO;
			shutdown <= 1'b1;
			sample_hold <= 1'b0;
			dac_code <= `RES_ZERO;
			dout_out <= 1'b0;
			dout_oe_n <= 1'b1;
		end else if (!selected) begin
			// everything idles and the output floats while deselected
			step_reg <= `STEP_ZERO;
			shutdown <= 1'b1;
			sample_hold <= 1'b0;
			dac_code <= `RES_ZERO;
			dout_out <= 1'b0;
			dout_oe_n <= 1'b1;
			cyc_reg <= `CYC_CNT_ZERO;
		end else if (sel_fall) begin
			// fresh select: restart, track input, latch format
			step_reg <= `STEP_ZERO;
			sar_reg <= `RES_ZERO;
			trial_reg <= `RES_ZERO;
			dual_reg <= fmt_sync_reg[1];
			shutdown <= 1'b0;
			sample_hold <= 1'b1;
			dac_code <= `RES_ZERO;
			dout_out <= 1'b0;
			dout_oe_n <= 1'b0;
			cyc_reg <= `CYC_CNT_ZERO;
		end else begin
			dout_oe_n <= 1'b0;
			// count clocks, saturate well above either least time
			if (cyc_reg != {`CYC_CNT_W{1'b1}}) begin
				cyc_reg <= cyc_reg + {{(`CYC_CNT_W-1){1'b0}}, 1'b1};
			end
			if (sclk_fall) begin
				// step counter saturates; staying selected never restarts
				if (step_reg != `STEP_MAX) begin
					step_reg <= step_reg + {{(`STEP_W-1){1'b0}}, 1'b1};
				end
				if (step_reg + {{(`STEP_W-1){1'b0}}, 1'b1} == `STEP_HOLD) begin
					// end of sampling: hold and try the msb
					sample_hold <= 1'b0;
					trial_reg <= {1'b1, {(`RES_W-1){1'b0}}};
					dac_code <= {1'b1, {(`RES_W-1){1'b0}}};
					dout_out <= 1'b0;
				end else if (step_reg + {{(`STEP_W-1){1'b0}}, 1'b1} >= `STEP_MSB &&
					step_reg + {{(`STEP_W-1){1'b0}}, 1'b1} <= `STEP_LSB) begin
					// decide the trial bit, show it, move trial down one bit
					sar_reg[fwd_index(step_reg + {{(`STEP_W-1){1'b0}}, 1'b1})] <= cmp_sync_reg[1];
					dout_out <= cmp_sync_reg[1];
					trial_reg <= trial_reg >> 1;
					dac_code <= (sar_reg & ~trial_reg) | (cmp_sync_reg[1] ? trial_reg : `RES_ZERO)
						| (trial_reg >> 1);
				end else if (dual_reg && step_reg + {{(`STEP_W-1){1'b0}}, 1'b1} >= `STEP_REV_FIRST &&
					step_reg + {{(`STEP_W-1){1'b0}}, 1'b1} <= `STEP_END_DUAL) begin
					// lsb-first repeat of the finished word
					dout_out <= sar_reg[rev_index(step_reg + {{(`STEP_W-1){1'b0}}, 1'b1})];
				end else begin
					// step 1, msb-only step 15 and every step after the format ends
					dout_out <= 1'b0;
				end
			end
		end
	end

	// hand finished words to the fifo; a busy fifo holds the word here
	always @(posedge clk) begin
		if (rst) begin
			pend_reg <= 1'b0;
			pend_data_reg <= `RES_ZERO;
			pend_short_reg <= 1'b0;
			result_overrun <= 1'b0;
		end else begin
			if (selected && sclk_fall && !sel_fall &&
				step_reg + {{(`STEP_W-1){1'b0}}, 1'b1} == `STEP_LSB) begin
				if (pend_reg && !fifo_ready) begin
					// previous word still stuck: drop the new one, flag it
					result_overrun <= 1'b1;
				end else begin
					pend_reg <= 1'b1;
					pend_data_reg <= {sar_reg[`RES_W-1:1], cmp_sync_reg[1]};
					pend_short_reg <= cyc_short;
				end
			end else if (pend_reg && fifo_ready) begin
				pend_reg <= 1'b0;
			end
		end
	end

	// result port registered from the fifo head
	always @(posedge clk) begin
		if (rst) begin
			result_valid <= 1'b0;
			result_data <= `RES_ZERO;
			result_short <= 1'b0;
		end else begin
			if (!result_valid || result_ready) begin
				result_valid <= fifo_out_valid;
				result_data <= fifo_out_data;
			end
			// timing quality of the latest word handed to the fifo
			if (pend_reg && fifo_ready) begin
				result_short <= pend_short_reg;
			end
		end
	end

	// eight-word result buffer
	sample_fifo #(
		.WIDTH(`FIFO_W),
		.DEPTH(`FIFO_D),
		.AW(`FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(pend_reg),
		.in_ready(fifo_ready),
		.in_data(pend_data_reg),
		.out_valid(fifo_out_valid),
		.out_ready(!result_valid || result_ready),
		.out_data(fifo_out_data)
	);
endmodule // serial_sar_adc_readout

// *** shared/adc_readout_defines.vh ***
// constants for the serial sar converter read-out block
`ifndef ADC_READOUT_DEFINES_VH
`define ADC_READOUT_DEFINES_VH

// result word
`define RES_W 12
`define RES_MSB 4'hb
`define RES_ZERO 12'h000
// serial step counter (falling serial clock edges since select)
`define STEP_W 5
`define STEP_ZERO 5'h00
`define STEP_MAX 5'h1f
`define STEP_HOLD 5'h02
`define STEP_MSB 5'h03
`define STEP_LSB 5'h0e
`define STEP_END_MSB 5'h0f
`define STEP_REV_FIRST 5'h0f
`define STEP_END_DUAL 5'h1a
// fifo shape
`define FIFO_W 12
`define FIFO_D 8
`define FIFO_AW 3
// cycle time figures, nanoseconds, and clock period
`define CYC_HI_NS 30100
`define CYC_LO_NS 45150
`define CLK_NS 5
`define CYC_CNT_W 14
`define CYC_CNT_ZERO 14'h0000

`endif

// *** verif/adc_readout_monitor.sv ***
// port checker for the converter read-out block
module adc_readout_monitor #(
	parameter CYC_HI_CLKS = 6020,
	parameter CYC_LO_CLKS = 9030
) (
	// clock, reset, serial pins
	input wire clk,
	input wire rst,
	input wire select_shutdown_n,
	input wire sclk,
	input wire dout_out,
	input wire dout_oe_n,
	// front end and stream
	input wire sample_hold,
	input wire [11:0] dac_code,
	input wire shutdown,
	input wire result_valid,
	input wire result_ready,
	input wire [11:0] result_data,
	input wire result_overrun
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// pin high long enough to clear the synchroniser
	sequence desel_held;
		select_shutdown_n [*5];
	endsequence
	sequence sel_start;
		$fell(select_shutdown_n);
	endsequence
	// end of sampling while awake
	sequence msb_trial;
		$fell(sample_hold) && !shutdown;
	endsequence
	desel_float_a: assert property (desel_held |-> dout_oe_n) else $error("pin driven when off");
	desel_power_a: assert property (desel_held |-> shutdown) else $error("awake when off");
	shut_idle_a: assert property (shutdown |-> dout_oe_n && !sample_hold) else $error("busy in shutdown");
	sel_wake_a: assert property (sel_start |-> ##[2:6] (!shutdown && !dout_oe_n && sample_hold))
		else $error("no wake on select");
	hold_msb_a: assert property (msb_trial |-> dac_code == 12'h800) else $error("first trial not msb");
	// data moves only while the serial clock has been low
	dout_quiet_a: assert property ($changed(dout_out) |-> !$past(sclk) && !$past(sclk, 2))
		else $error("data moved off a falling edge");
	stream_hold_a: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
		else $error("word changed before taken");
	overrun_stick_a: assert property (result_overrun |=> result_overrun) else $error("overrun flag lost");
endmodule // adc_readout_monitor

bind serial_sar_adc_readout adc_readout_monitor #(.CYC_HI_CLKS(CYC_HI_CLKS), .CYC_LO_CLKS(CYC_LO_CLKS))
	adc_readout_monitor_i (.clk(clk), .rst(rst), .select_shutdown_n(select_shutdown_n), .sclk(sclk),
	.dout_out(dout_out), .dout_oe_n(dout_oe_n), .sample_hold(sample_hold), .dac_code(dac_code),
	.shutdown(shutdown), .result_valid(result_valid), .result_ready(result_ready),
	.result_data(result_data), .result_overrun(result_overrun));

// *** verif/serial_host.sv ***
// host serial master model: select, serial clock, bit capture
module serial_host (
	// clock
	input wire clk,
	// serial pins
	output logic select_shutdown_n,
	output logic sclk,
	input wire dout_oe_n,
	input wire dout_line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic got[$]; // bits seen at each rising edge
	// idle: deselected, clock parked low
	initial begin
		select_shutdown_n = 1'b1;
		sclk = 1'b0;
	end
	// one frame of n clocks, 6 and 7 cycle halves give 65 ns
	task automatic frame(input int n);
		@(posedge clk);
		select_shutdown_n <= 1'b0;
		repeat (6) @(posedge clk);
		repeat (n) begin
			sclk <= 1'b1;
			repeat (6) @(posedge clk);
			sclk <= 1'b0;
			repeat (7) @(posedge clk);
			// undriven pin is captured as unknown
			got.push_back(dout_oe_n ? 1'bx : dout_line);
		end
		select_shutdown_n <= 1'b1;
		repeat (20) @(posedge clk);
	endtask
endmodule // serial_host

// *** verif/test_serial_sar_adc_readout.sv ***
// self-checking bench for the converter read-out block
module test_serial_sar_adc_readout;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, dual_format = 1'b0, low_supply = 1'b0, cmp_above = 1'b0, result_ready = 1'b0;
	wire select_shutdown_n, sclk, dout_in, dout_out, dout_oe_n, sample_hold, shutdown;
	wire result_valid, result_short, result_overrun;
	wire [11:0] dac_code, result_data;
	int failures = 0, compares = 0, seed = 68777, held = 0;
	logic fill = 1'b0; // sink stalls while the buffer fills
	logic short_e = 1'b0; // model: short flag of the last word buffered
	logic [11:0] vin = 12'h000; // input level in lsb
	logic [11:0] exp_q[$]; // words the model expects
	always #2.5 clk = ~clk;
	// released pin toggles so stale data cannot match
	assign dout_in = dout_oe_n ? clk : dout_out;
	serial_sar_adc_readout #(.CYC_HI_CLKS(150), .CYC_LO_CLKS(300)) serial_sar_adc_readout_i (.clk(clk),
		.rst(rst), .select_shutdown_n(select_shutdown_n), .sclk(sclk), .dout_in(dout_in), .dout_out(dout_out),
		.dout_oe_n(dout_oe_n), .dual_format(dual_format), .low_supply(low_supply), .cmp_above(cmp_above),
		.sample_hold(sample_hold), .dac_code(dac_code), .shutdown(shutdown), .result_valid(result_valid),
		.result_ready(result_ready), .result_data(result_data), .result_short(result_short),
		.result_overrun(result_overrun));
	serial_host serial_host_i (.clk(clk), .select_shutdown_n(select_shutdown_n), .sclk(sclk),
		.dout_oe_n(dout_oe_n), .dout_line(dout_in));
	task automatic chk_b(string what, logic e, logic g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic chk_w(string what, logic [11:0] e, logic [11:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// comparator: trial level sits half an lsb below its code
	always @(posedge clk) begin
		cmp_above <= (dac_code <= vin);
		result_ready <= !fill && $random(seed) % 2;
		if (result_valid === 1'b1 && result_ready === 1'b1) chk_w("result word", exp_q.pop_front(), result_data);
	end
	// one conversion; format flipped mid-frame must be ignored
	task automatic conv(logic [11:0] v, logic d);
		int n;
		logic e;
		n = d ? 28 : 17;
		@(posedge clk);
		vin <= v;
		dual_format <= d;
		low_supply <= ~low_supply;
		// stalled sink holds 10 words: output stage, 8 buffered, 1 pending
		if (!fill || held < 9) short_e = ~low_supply;
		if (!fill || held < 10) exp_q.push_back(v);
		held += fill;
		serial_host_i.got.delete();
		fork
			serial_host_i.frame(n);
			begin
				repeat (30) @(posedge clk);
				dual_format <= !d;
			end
		join
		for (int k = 1; k <= n; k++) begin
			e = (k >= 3 && k <= 14) ? v[14-k] : (d && k >= 15 && k <= 26) ? v[k-15] : 1'b0;
			chk_b("serial bit", e, serial_host_i.got[k-1]);
		end
		chk_b("shutdown", 1'b1, shutdown);
		chk_b("output enable", 1'b1, dout_oe_n);
		chk_b("short flag", short_e, result_short);
	endtask
	// watchdog: 20 frames of about 250 to 400 cycles, with margin
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		wrap_up();
	end
	initial begin
		logic [11:0] codes[5] = '{12'h000, 12'h800, 12'hfff, 12'h001, 12'h7ff};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk_b("shutdown after reset", 1'b1, shutdown);
		foreach (codes[i]) conv(codes[i], i[0]);
		repeat (4) conv(12'($random(seed)), 1'($random(seed)));
		for (int t = 0; t < 300 && exp_q.size() > 0; t++) @(posedge clk);
		$display("test codes and formats done");
		fill <= 1'b1;
		repeat (11) conv(12'($random(seed)), 1'b0);
		chk_b("overrun flag", 1'b1, result_overrun);
		$display("test buffer fill done");
		fill <= 1'b0;
		for (int t = 0; t < 400 && exp_q.size() > 0; t++) @(posedge clk);
		repeat (5) @(posedge clk);
		chk_b("buffer empty", 1'b0, result_valid);
		chk_b("all words seen", 1'b1, exp_q.size() == 0);
		$display("test buffer drain done");
		wrap_up();
	end
endmodule // test_serial_sar_adc_readout
